// file: ddsl_device.sv
// converter front end: shift register, input and output registers
//
// Contract
// (RULE_01) sixteen-bit words, most significant bit first
// (RULE_02) shift on serial clock rise while selected
// (RULE_03) bits 15,14 address; 13..0 code
// (RULE_04) extra bits dropped; last sixteen used
// (RULE_05) select rise loads code into input registers
// (RULE_06) address 00 none, 01 A, 10 B, 11 both
// (RULE_07) byte master keeps select low between bytes
// (RULE_08) load strobe low: output registers follow inputs
// (RULE_09) preset low forces zero or half scale
// (RULE_10) reset forces zero or half scale
// (RULE_11) outputs keep preset value until a load
// (RULE_12) unused preset held high by system
// (RULE_13) idle clock or deselected edges change nothing
// (RULE_14) select never gates the load strobe
// (RULE_15) preset wins over loads and transfers
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module ddsl_device
  import ddsl_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  ddsl_if.device link,
  output logic [CODE_W-1:0] input_a_o,
  output logic [CODE_W-1:0] input_b_o,
  output logic [CODE_W-1:0] out_a_o,
  output logic [CODE_W-1:0] out_b_o
);
  // pin bank: raw level, first and second synchroniser stage
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_m_q;
  logic [PIN_N-1:0] pin_s_q;

  // delayed copies of settled clock and select, for edges
  logic sclk_e_q;
  logic sel_e_q;

  // power-up pass shift chain
  logic [2:0] boot_q;

  // serial word and per-channel register pairs
  logic [WORD_W-1:0] shift_q;
  logic [CODE_W-1:0] in_q [CHAN_N];
  logic [CODE_W-1:0] dac_q [CHAN_N];

  // decoded strobes
  logic sclk_rise;
  logic sel_rise;
  logic force_now;
  logic [CODE_W-1:0] preset_val;
  logic [CHAN_N-1:0] load_ch;

  // pins gathered in one bank so each gets the same synchroniser
  assign pin_raw[PIN_SCLK] = link.sclk;
  assign pin_raw[PIN_SEL] = link.select_n;
  assign pin_raw[PIN_DIN] = link.serial_in;
  assign pin_raw[PIN_LOAD] = link.load_outputs_n;
  assign pin_raw[PIN_PRE] = link.preset_n;
  assign pin_raw[PIN_LVL] = link.level_sel;

  // two flops per pin, reset to the idle level so no false edge follows reset
  for (genvar p = 0; p < PIN_N; p++)
  begin : g_sync
    always_ff @(posedge clock_i)
    begin
      if (!resetn_i)
      begin
        pin_m_q[p] <= PIN_IDLE[p];
        pin_s_q[p] <= PIN_IDLE[p];
      end
      else
      begin
        pin_m_q[p] <= pin_raw[p];
        pin_s_q[p] <= pin_m_q[p];
      end
    end
  end

  // edge stage reads only the second flop, never the first
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      sclk_e_q <= PIN_IDLE[PIN_SCLK];
      sel_e_q <= PIN_IDLE[PIN_SEL];
    end
    else
    begin
      sclk_e_q <= pin_s_q[PIN_SCLK];
      sel_e_q <= pin_s_q[PIN_SEL];
    end
  end

  // power-up pass: the level pin needs two clocks before it can pick the value
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      boot_q <= BOOT_INIT;
    end
    else
    begin
      boot_q <= {1'b0, boot_q[2:1]}; // [RULE_10]
    end
  end

  // edges; static clock levels produce none, deselected edges are masked
  assign sclk_rise = pin_s_q[PIN_SCLK] & ~sclk_e_q & ~pin_s_q[PIN_SEL]; // [RULE_02] [RULE_13]
  assign sel_rise = pin_s_q[PIN_SEL] & ~sel_e_q; // [RULE_05]

  // preset pin or power-up pass; both force the value the level pin picks
  assign force_now = !pin_s_q[PIN_PRE] || boot_q[0]; // [RULE_09] [RULE_10] [RULE_15]
  assign preset_val = pin_s_q[PIN_LVL] ? HALF_CODE : ZERO_CODE; // [RULE_09]

  // shift register, msb first; older bits fall off the top
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      shift_q <= '0;
    end
    else if (sclk_rise)
    begin
      shift_q <= {shift_q[WORD_W-2:0], pin_s_q[PIN_DIN]}; // [RULE_01] [RULE_04]
    end
  end

  // one slice per channel: index 0 is channel a on bit 14, index 1 channel b on bit 15
  for (genvar ch = 0; ch < CHAN_N; ch++)
  begin : g_chan
    // each address bit enables its own channel, so 11 loads both with one code
    assign load_ch[ch] = sel_rise && shift_q[ADDR_LO_POS + ch]; // [RULE_03] [RULE_06]

    // input register; preset checked first so it beats a select-edge load
    always_ff @(posedge clock_i)
    begin
      if (!resetn_i)
      begin
        in_q[ch] <= ZERO_CODE;
      end
      else if (force_now)
      begin
        in_q[ch] <= preset_val; // [RULE_09] [RULE_15]
      end
      else if (load_ch[ch])
      begin
        in_q[ch] <= shift_q[CODE_W-1:0]; // [RULE_05]
      end
    end

    // output register follows while the strobe is low; select plays no part
    always_ff @(posedge clock_i)
    begin
      if (!resetn_i)
      begin
        dac_q[ch] <= ZERO_CODE;
      end
      else if (force_now)
      begin
        dac_q[ch] <= preset_val; // [RULE_09] [RULE_15]
      end
      else if (!pin_s_q[PIN_LOAD])
      begin
        dac_q[ch] <= in_q[ch]; // [RULE_08] [RULE_14]
      end
      // otherwise hold the preset or last loaded value [RULE_11]
    end
  end

  // channel slices to the named outputs
  assign input_a_o = in_q[0];
  assign input_b_o = in_q[1];
  assign out_a_o = dac_q[0];
  assign out_b_o = dac_q[1];
endmodule

// file: ddsl_pkg.sv
// package with shared constants for the dual converter serial load link
package ddsl_pkg;
  localparam int WORD_W = 16;
  localparam int CODE_W = 14;
  localparam int ADDR_HI_POS = 15;
  localparam int ADDR_LO_POS = 14;
  localparam logic [CODE_W-1:0] ZERO_CODE = 14'h0000;
  localparam logic [CODE_W-1:0] HALF_CODE = 14'h2000;
  localparam logic [1:0] ADDR_NONE = 2'h0;
  localparam logic [1:0] ADDR_A = 2'h1;
  localparam logic [1:0] ADDR_B = 2'h2;
  localparam logic [1:0] ADDR_BOTH = 2'h3;
  // link clock half period in system clocks (80 ns at 4 ns)
  localparam int LINK_HALF_NS = 80;
  localparam int CLK_NS = 4;
  localparam int LINK_HALF_CYC = LINK_HALF_NS / CLK_NS;
  localparam logic [4:0] LINK_HALF_CNT = 5'(LINK_HALF_CYC - 1);
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam int CTRL_LOAD_POS = 0;
  localparam int CTRL_PRESET_POS = 1;
  localparam int CTRL_LEVEL_POS = 2;
  localparam int CTRL_SPLIT_POS = 3;
  localparam logic [3:0] CTRL_RESET = 4'h3;
  // frame length and byte split point in serial clock rises
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] SPLIT_BITS = 5'h08;
  // synchroniser bank positions and idle levels of the link pins
  localparam int PIN_N = 6;
  localparam int PIN_SCLK = 0;
  localparam int PIN_SEL = 1;
  localparam int PIN_DIN = 2;
  localparam int PIN_LOAD = 3;
  localparam int PIN_PRE = 4;
  localparam int PIN_LVL = 5;
  localparam logic [5:0] PIN_IDLE = 6'h1A;
  // power-up preset pass, long enough for the level pin to settle
  localparam logic [2:0] BOOT_INIT = 3'h7;
  localparam int CHAN_N = 2;
endpackage

// file: ddsl_if.sv
// interface joining the serial master and the converter front end
`timescale 1ns/1ps
interface ddsl_if;
  logic sclk;
  logic select_n;
  logic serial_in;
  logic load_outputs_n;
  logic preset_n;
  logic level_sel;
  modport device (input sclk, input select_n, input serial_in, input load_outputs_n, input preset_n, input level_sel);
  modport host (output sclk, output select_n, output serial_in, output load_outputs_n, output preset_n,
    output level_sel);
endinterface

// file: ddsl_host.sv
// serial master: sends words over the link from a register port
`timescale 1ns/1ps
module ddsl_host
  import ddsl_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  ddsl_if.host link,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_GAP} ddsl_state_t;
  ddsl_state_t state_q;
  logic [WORD_W-1:0] word_q;
  logic [4:0] bits_q;
  logic [4:0] tick_q;
  logic [3:0] ctrl_q;
  logic sclk_q;
  logic sel_n_q;
  logic dout_q;
  logic [31:0] rdata_q;
  logic start;
  logic tick_done;

  assign start = wr_i && (addr_i == REG_CMD) && (state_q == ST_IDLE);
  assign tick_done = (tick_q == LINK_HALF_CNT);

  // control register: strobe, preset, level, byte split
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      ctrl_q <= CTRL_RESET;
    else if (wr_i && addr_i == REG_CTRL)
      ctrl_q <= wdata_i[3:0];
  end

  // half-period counter for the divided link clock
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i || state_q == ST_IDLE || tick_done)
      tick_q <= 5'h00;
    else
      tick_q <= tick_q + 5'h01;
  end

  // frame sequencer; data changes on falling clock, msb first
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      state_q <= ST_IDLE;
      sel_n_q <= 1'b1;
      sclk_q <= 1'b0;
      dout_q <= 1'b0;
      word_q <= '0;
      bits_q <= 5'h00;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (start)
          begin
            word_q <= wdata_i[WORD_W-1:0];
            dout_q <= wdata_i[WORD_W-1]; // [RULE_01] [RULE_03]
            sel_n_q <= 1'b0;
            bits_q <= 5'h00;
            state_q <= ST_LOW;
          end
        ST_LOW:
          if (tick_done)
          begin
            sclk_q <= 1'b1;
            bits_q <= bits_q + 5'h01;
            state_q <= ST_HIGH;
          end
        ST_HIGH:
          if (tick_done)
          begin
            sclk_q <= 1'b0;
            word_q <= {word_q[WORD_W-2:0], 1'b0};
            dout_q <= word_q[WORD_W-2];
            // byte split keeps select low across the pause
            if (bits_q == FRAME_BITS)
              state_q <= ST_GAP;
            else if (ctrl_q[CTRL_SPLIT_POS] && bits_q == SPLIT_BITS)
              state_q <= ST_GAP; // [RULE_07]
            else
              state_q <= ST_LOW;
          end
        ST_GAP:
          if (tick_done)
          begin
            if (bits_q == FRAME_BITS)
            begin
              sel_n_q <= 1'b1;
              state_q <= ST_IDLE;
            end
            else
              state_q <= ST_LOW;
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      rdata_q <= 32'h0;
    else if (rd_i)
      case (addr_i)
        REG_STATUS: rdata_q <= {31'h0, state_q != ST_IDLE};
        REG_CTRL: rdata_q <= {28'h0, ctrl_q};
        default: rdata_q <= 32'h0;
      endcase
  end

  assign rdata_o = rdata_q;
  assign link.sclk = sclk_q;
  assign link.select_n = sel_n_q;
  assign link.serial_in = dout_q;
  assign link.load_outputs_n = ctrl_q[CTRL_LOAD_POS];
  assign link.preset_n = ctrl_q[CTRL_PRESET_POS]; // [RULE_12]
  assign link.level_sel = ctrl_q[CTRL_LEVEL_POS];
endmodule

// file: ddsl_chk.sv
// checker for the serial load link and converter registers
`timescale 1ns/1ps
module ddsl_chk
  import ddsl_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic sclk,
  input wire logic select_n,
  input wire logic serial_in,
  input wire logic load_outputs_n,
  input wire logic preset_n,
  input wire logic level_sel,
  input wire logic [CODE_W-1:0] input_a_o,
  input wire logic [CODE_W-1:0] input_b_o,
  input wire logic [CODE_W-1:0] out_a_o,
  input wire logic [CODE_W-1:0] out_b_o
);
  logic sclk_q;
  logic [4:0] rises_q;
  logic [WORD_W-1:0] word_q;
  logic [3:0] quiet_q;
  logic [3:0] calm_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // rebuild the word from the wire at each serial clock rise
  always_ff @(posedge clock_i)
  begin
    sclk_q <= sclk;
    rises_q <= select_n ? 5'h00 : rises_q + {4'h0, sclk && !sclk_q};
    if (!select_n && sclk && !sclk_q)
      word_q <= {word_q[WORD_W-2:0], serial_in};
  end
  // saturating time since strobe or select activity, so holds can be judged
  always_ff @(posedge clock_i)
  begin
    quiet_q <= (!resetn_i || !load_outputs_n || !preset_n) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
    calm_q <= (!resetn_i || !select_n || !preset_n) ? 4'h0 : calm_q + {3'h0, calm_q != 4'hF};
  end
  a_frame_count: assert property ($rose(select_n) |-> rises_q == 5'h10) else $error("bad bit count");
  a_load_chan_a: assert property ($rose(select_n) && preset_n && word_q[ADDR_LO_POS] |-> ##[2:8]
    input_a_o == word_q[CODE_W-1:0]) else $error("channel a not loaded");
  a_load_chan_b: assert property ($rose(select_n) && preset_n && word_q[ADDR_HI_POS] |-> ##[2:8]
    input_b_o == word_q[CODE_W-1:0]) else $error("channel b not loaded");
  a_load_none: assert property ($rose(select_n) && word_q[15:14] == ADDR_NONE |->
    ($stable(input_a_o) && $stable(input_b_o))[*6]) else $error("none address loaded");
  a_preset_value: assert property ((!preset_n && $stable(level_sel))[*6] |->
    {input_a_o, input_b_o, out_a_o, out_b_o} == {4{level_sel ? HALF_CODE : ZERO_CODE}}) else $error("bad preset");
  a_out_follow: assert property ((!load_outputs_n && preset_n && $stable(input_a_o) && $stable(input_b_o))[*6] |->
    out_a_o == input_a_o && out_b_o == input_b_o) else $error("outputs not transparent");
  a_out_hold: assert property ($changed(out_a_o) || $changed(out_b_o) |-> quiet_q < 4'h6) else $error("output moved");
  a_in_hold: assert property ($changed(input_a_o) || $changed(input_b_o) |-> calm_q < 4'h8) else $error("input moved");
  c_frame: cover property ($rose(select_n));
  c_preset: cover property (!preset_n && level_sel);
  c_follow: cover property (!load_outputs_n && $changed(out_a_o));
endmodule

// file: tb.sv
// testbench driving the host register port and watching the converter
`timescale 1ns/1ps
module tb;
  import ddsl_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [31:0] d;
  logic [CODE_W-1:0] in_a, in_b, out_a, out_b, ea, eb, c;
  logic [WORD_W-1:0] wire_q;
  logic sclk_q;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  ddsl_if link_if();
  ddsl_host u_ddsl_host (.clock_i(clock_i), .resetn_i(resetn_i), .link(link_if), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  ddsl_device u_ddsl_device (.clock_i(clock_i), .resetn_i(resetn_i), .link(link_if), .input_a_o(in_a),
    .input_b_o(in_b), .out_a_o(out_a), .out_b_o(out_b));
  ddsl_chk u_ddsl_chk (.clock_i(clock_i), .resetn_i(resetn_i), .sclk(link_if.sclk), .select_n(link_if.select_n),
    .serial_in(link_if.serial_in), .load_outputs_n(link_if.load_outputs_n), .preset_n(link_if.preset_n),
    .level_sel(link_if.level_sel), .input_a_o(in_a), .input_b_o(in_b), .out_a_o(out_a), .out_b_o(out_b));
  always #2 clock_i = ~clock_i;
  // wire capture at serial clock rises inside a frame; cycle limit
  always @(posedge clock_i)
  begin
    sclk_q <= link_if.sclk;
    if (link_if.sclk && !sclk_q && !link_if.select_n)
      wire_q <= {wire_q[WORD_W-2:0], link_if.serial_in};
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic regs(input logic [CODE_W-1:0] a, b, oa, ob);
    chk(32'({in_a, in_b}), 32'({a, b}));
    chk(32'({out_a, out_b}), 32'({oa, ob}));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // one frame, polled until idle, then the wire word is compared
  task automatic send(input logic [WORD_W-1:0] w);
    wr(REG_CMD, {16'h0000, w});
    d = 32'h1;
    for (int i = 0; i < 1000 && d[0]; i++)
      rd(REG_STATUS);
    chk(d, 32'h0);
    repeat (8) @(posedge clock_i);
    chk(32'(wire_q), 32'(w));
  endtask
  initial
  begin
    repeat (12) @(posedge clock_i);
    resetn_i <= 1'b1;
    regs(ZERO_CODE, ZERO_CODE, ZERO_CODE, ZERO_CODE);
    rd(8'h0C);
    chk(d, 32'h0);
    ea = ZERO_CODE;
    eb = ZERO_CODE;
    // every address code; outputs must keep their reset value
    for (int k = 0; k < 4; k++)
    begin
      c = 14'h1A5C + 14'(k) * 14'h0111;
      send({2'(k), c});
      if (k[0]) ea = c;
      if (k[1]) eb = c;
      regs(ea, eb, ZERO_CODE, ZERO_CODE);
    end
    wr(REG_CTRL, 32'h2);
    rd(REG_CTRL);
    chk(d, 32'h2);
    repeat (8) @(posedge clock_i);
    regs(ea, eb, ea, eb);
    wr(REG_CTRL, 32'hA);
    send({ADDR_A, 14'h3FFF});
    regs(14'h3FFF, eb, 14'h3FFF, eb);
    wr(REG_CTRL, 32'h3);
    send({ADDR_B, 14'h0001});
    regs(14'h3FFF, 14'h0001, 14'h3FFF, eb);
    wr(REG_CTRL, 32'h5);
    send({ADDR_BOTH, 14'h1555});
    regs(HALF_CODE, HALF_CODE, HALF_CODE, HALF_CODE);
    wr(REG_CTRL, 32'h1);
    repeat (8) @(posedge clock_i);
    regs(ZERO_CODE, ZERO_CODE, ZERO_CODE, ZERO_CODE);
    report_and_stop();
  end
endmodule
